// *** rtl/icu_map.svh ***
// Register offsets, field positions and reset values of the interrupt unit
`ifndef ICU_MAP_SVH
`define ICU_MAP_SVH
`define NUM_IRQ        16
`define NUM_FAST       8
`define OFF_VEC        8'h00
`define OFF_FVEC       8'h04
`define OFF_LOCK       8'h08
`define OFF_SELA       8'h0c
`define OFF_SELB       8'h10
`define OFF_ACK        8'h14
`define OFF_FACK       8'h18
`define OFF_CLR        8'h1c
`define OFF_GLOBAL_IRQ_DISABLE    8'h20
`define OFF_END        8'h24
`define OFF_FEND       8'h28
`define OFF_FPRIO0     8'h2c
`define OFF_FPRIO7     8'h48
`define OFF_FISR       8'h4c
`define OFF_FIRR       8'h50
`define OFF_FMASK      8'h54
`define OFF_IRR        8'h58
`define OFF_MASK       8'h5c
`define OFF_ISR        8'h60
`define OFF_TRIG       8'h64
`define OFF_EDGE       8'h68
`define OFF_SW         8'h6c
`define OFF_PRIO0      8'h70
`define OFF_PRIO15     8'hac
`define EN_BIT         7
`define VEC_DEFAULT    32'hffff_ffff
`define PRIO_RST       4'hf
`define FPRIO_RST      3'h7
`define MASK_RST       16'hffff
`define FMASK_RST      8'hff
`define GLOBAL_IRQ_DISABLE_RST    1'b1
`define LANE_A         6
`define LANE_B         7
`endif

// *** rtl/icu_pkg.sv ***
// Shared types of the interrupt unit
package icu_pkg;
  typedef logic [3:0] irq_prio_t;
  typedef logic [2:0] fast_prio_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
endpackage

// *** rtl/resolver_if.sv ***
// Pending, in-service and priority bundle between core and priority resolver
`timescale 1ns/1ps
interface resolver_if #(
  parameter int N  = 16,
  parameter int PW = 4
);
  logic [N-1:0]         pend;
  logic [N-1:0]         ins;
  logic [N*PW-1:0]      prio;
  logic                 lock_en;
  logic [PW-1:0]        lock_prio;
  logic                 win_valid;
  logic [$clog2(N)-1:0] win_idx;
  logic [PW-1:0]        win_prio;
  logic                 top_valid;
  logic [$clog2(N)-1:0] top_idx;
  logic [PW-1:0]        top_prio;
  modport core (output pend, ins, prio, lock_en, lock_prio,
                input win_valid, win_idx, win_prio, top_valid, top_idx, top_prio);
  modport solver (input pend, ins, prio, lock_en, lock_prio,
                  output win_valid, win_idx, win_prio, top_valid, top_idx, top_prio);
endinterface

// *** rtl/prio_resolver.sv ***
// Priority resolver: pending winner and highest-priority in-service input
`timescale 1ns/1ps
module prio_resolver #(
  parameter int N  = 16,
  parameter int PW = 4
)(
  resolver_if.solver rif
);
  localparam int IW = $clog2(N);

  always_comb
  begin
    logic [PW-1:0] p;
    p             = '0;
    rif.top_valid = 1'b0;
    rif.top_idx   = '0;
    rif.top_prio  = '1;
    rif.win_valid = 1'b0;
    rif.win_idx   = '0;
    rif.win_prio  = '1;
    // Equal priorities resolve to the lower index; duplicates are not flagged
    for (int i = 0; i < N; i++)
    begin
      p = rif.prio[i*PW +: PW];
      if (rif.ins[i] && (!rif.top_valid || p < rif.top_prio))
      begin
        rif.top_valid = 1'b1;
        rif.top_idx   = IW'(i);
        rif.top_prio  = p;
      end
    end
    for (int i = 0; i < N; i++)
    begin
      p = rif.prio[i*PW +: PW];
      if (rif.pend[i]
          && (!rif.top_valid || p < rif.top_prio)        // [RULE22]
          && (!rif.lock_en || p < rif.lock_prio)         // [RULE11] [RULE12]
          && (!rif.win_valid || p < rif.win_prio))       // [RULE8]
      begin
        rif.win_valid = 1'b1;
        rif.win_idx   = IW'(i);
        rif.win_prio  = p;
      end
    end
  end
endmodule

// *** rtl/nested_vectored_interrupt_unit.sv ***
// Nested vectored interrupt unit with normal and fast sections, AXI4-Lite slave
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "icu_map.svh"

// Overview of operation
// [RULE1] A fast section with eight request inputs exists beside the normal one.
// [RULE2] Normal section has sixteen inputs; two may be handled as fast requests.
// [RULE3] Two select settings reroute a chosen normal input onto fast input 6 or 7.
// [RULE4] Each select setting has an enable bit, clear at reset, else no reroute.
// [RULE5] Software masks in the normal section every input it made fast.
// [RULE6] Bus-error fast inputs give two-cycle pulses; software sets them edge mode.
// [RULE7] Sources on faster clocks stretch requests to be seen at this clock.
// [RULE8] Priorities 0..15 normal, 0..7 fast; zero is the highest.
// [RULE9] Reset sets normal priorities to 15 and fast priorities to 7.
// [RULE10] Software keeps priorities unique; no duplicate check is made.
// [RULE11] Active lock blocks normal requests of priority lower or equal to lock value.
// [RULE12] Locking applies only while the lock enable bit is set; reset clears it.
// [RULE13] Request racing a lock write may raise output; dropped within two cycles.
// [RULE14] Each input edge or level; rising edge default; level is active high.
// [RULE15] Edge requests last one cycle; level requests hold until acknowledged.
// [RULE16] Normal requests latch regardless of mask; mask gates only priority path.
// [RULE17] Normal masks disable all at reset; a global disable gates all above them.
// [RULE18] Fast section has per-input masks only, disabling at reset.
// [RULE19] Writing a bit number to the clear register clears that normal request.
// [RULE20] Software request bits enter normal requests directly, several at once.
// [RULE21] Acknowledge sets in-service bit, clears request bit, drops output.
// [RULE22] In-service blocks lower priority; higher priority may interrupt again.
// [RULE23] End command clears highest in-service bit; lower ones resume afterwards.
// [RULE24] Software keeps priorities unchanged while anything is in service.
// [RULE25] Vector readable at two addresses; first acknowledges, second has no effect. Here a read at 8'h14 acknowledges and one at 8'h00 has no effect.
// [RULE26] With nothing pending the vector reads all ones, also its reset value.
// [RULE27] Fast section acknowledges, nests and ends like the normal section.
module nested_vectored_interrupt_unit
  import icu_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [15:0]       irq_src,
  input  wire logic [7:0]        fast_src,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq_out,
  output logic                   fast_out
);
  localparam int NI = `NUM_IRQ;
  localparam int NF = `NUM_FAST;
  localparam int NT = NI + NF;

  logic [NT-1:0]  s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, f_q, f_d, prev_q, prev_d;
  logic [NT-1:0]  lv, det, trig_q, trig_d, edge_q, edge_d;
  logic [NF-1:0]  fast_in;
  logic [NI-1:0]  ireq_q, ireq_d, isr_q, isr_d, mask_q, mask_d, sw_q, sw_d;
  logic [NI-1:0]  clr, sw_set, iack_oh, ieoi_oh;
  logic [NF-1:0]  freq_q, freq_d, fisr_q, fisr_d, fmask_q, fmask_d, fack_oh, feoi_oh;
  logic [7:0]     lock_q, lock_d, sela_q, sela_d, selb_q, selb_d;
  logic           gdis_q, gdis_d, irq_q, irq_d, fiq_q, fiq_d;
  irq_prio_t      prio_q [NI];
  irq_prio_t      prio_d [NI];
  fast_prio_t     fprio_q [NF];
  fast_prio_t     fprio_d [NF];
  logic           aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]     awa_q, awa_d;
  logic [31:0]    wd_q, wd_d, rd_q, rd_d, m, nvec, fvec;
  logic [3:0]     ws_q, ws_d;
  axi_resp_t      br_q, br_d, rr_q, rr_d;
  logic           ar_fire, wr_go, iack, fack, ieoi, feoi;
  logic [32:0]    rhit, whit;

  resolver_if #(.N(NI), .PW(4)) nrif ();
  resolver_if #(.N(NF), .PW(3)) frif ();

  prio_resolver #(.N(NI), .PW(4)) u_norm (.rif(nrif));
  prio_resolver #(.N(NF), .PW(3)) u_fast (.rif(frif));

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  // Bit 32 marks a mapped, word-aligned address; upper address bits alias
  function automatic logic [32:0] regval(input logic [7:0] a);
    if (a[1:0] != 2'b00)
      return {1'b0, 32'h0};
    else if (a == `OFF_VEC || a == `OFF_ACK)
      return {1'b1, nvec};                                      // [RULE25]
    else if (a == `OFF_FVEC || a == `OFF_FACK)
      return {1'b1, fvec};
    else if (a == `OFF_LOCK)
      return {1'b1, 24'h0, lock_q};
    else if (a == `OFF_SELA)
      return {1'b1, 24'h0, sela_q};
    else if (a == `OFF_SELB)
      return {1'b1, 24'h0, selb_q};
    else if (a == `OFF_CLR || a == `OFF_END || a == `OFF_FEND)
      return {1'b1, 32'h0};
    else if (a == `OFF_GLOBAL_IRQ_DISABLE)
      return {1'b1, 31'h0, gdis_q};
    else if (a >= `OFF_FPRIO0 && a <= `OFF_FPRIO7)
      return {1'b1, 29'h0, fprio_q[3'((a - `OFF_FPRIO0) >> 2)]};
    else if (a == `OFF_FISR)
      return {1'b1, 24'h0, fisr_q};
    else if (a == `OFF_FIRR)
      return {1'b1, 24'h0, freq_q};
    else if (a == `OFF_FMASK)
      return {1'b1, 24'h0, fmask_q};
    else if (a == `OFF_IRR)
      return {1'b1, 16'h0, ireq_q};
    else if (a == `OFF_MASK)
      return {1'b1, 16'h0, mask_q};
    else if (a == `OFF_ISR)
      return {1'b1, 16'h0, isr_q};
    else if (a == `OFF_TRIG)
      return {1'b1, 8'h0, trig_q};
    else if (a == `OFF_EDGE)
      return {1'b1, 8'h0, edge_q};
    else if (a == `OFF_SW)
      return {1'b1, 16'h0, sw_q};
    else if (a >= `OFF_PRIO0 && a <= `OFF_PRIO15)
      return {1'b1, 28'h0, prio_q[4'((a - `OFF_PRIO0) >> 2)]};
    else
      return {1'b0, 32'h0};
  endfunction

  assign awready  = ~aw_q;
  assign wready   = ~w_q;
  assign arready  = ~rv_q;
  assign bvalid   = bv_q;
  assign bresp    = br_q;
  assign rvalid   = rv_q;
  assign rdata    = rd_q;
  assign rresp    = rr_q;
  assign irq_out  = irq_q;
  assign fast_out = fiq_q;
  assign ar_fire  = arvalid & ~rv_q;
  assign wr_go    = aw_q & w_q & ~bv_q;

  // Reroute uses the filtered normal level, so both sections see one source
  always_comb
  begin
    fast_in = f_q[NT-1:NI];                                      // [RULE1]
    if (sela_q[`EN_BIT])                                         // [RULE4]
      fast_in[`LANE_A] = f_q[sela_q[3:0]];                       // [RULE2] [RULE3]
    if (selb_q[`EN_BIT])
      fast_in[`LANE_B] = f_q[selb_q[3:0]];                       // [RULE3]
  end

  assign lv  = {fast_in, f_q[NI-1:0]};
  assign det = (trig_q & lv)                                     // [RULE14]
             | (~trig_q & edge_q & prev_q & ~lv)
             | (~trig_q & ~edge_q & lv & ~prev_q);

  // Three stages; a change counts once stages two and three agree
  always_comb
  begin
    s1_d   = {fast_src, irq_src};
    s2_d   = s1_q;
    s3_d   = s2_q;
    f_d    = (s2_q & s3_q) | (f_q & (s2_q | s3_q));              // [RULE7]
    prev_d = lv;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      f_q    <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      f_q    <= f_d;
      prev_q <= prev_d;
    end
  end

  always_comb
  begin
    nrif.pend      = ireq_q & ~mask_q & {NI{~gdis_q}};           // [RULE16] [RULE17]
    nrif.ins       = isr_q;
    nrif.lock_en   = lock_q[`EN_BIT];                            // [RULE12]
    nrif.lock_prio = lock_q[3:0];                                // [RULE11]
    frif.pend      = freq_q & ~fmask_q;                          // [RULE18]
    frif.ins       = fisr_q;                                     // [RULE27]
    frif.lock_en   = 1'b0;
    frif.lock_prio = '0;
    for (int i = 0; i < NI; i++)
      nrif.prio[i*4 +: 4] = prio_q[i];
    for (int i = 0; i < NF; i++)
      frif.prio[i*3 +: 3] = fprio_q[i];
  end

  assign nvec = nrif.win_valid ? {28'h0, nrif.win_idx} : `VEC_DEFAULT;  // [RULE26]
  assign fvec = frif.win_valid ? {29'h0, frif.win_idx} : `VEC_DEFAULT;
  // The decode function reads registers directly; a continuous assign would miss their changes
  always_comb
  begin
    rhit = regval(araddr[7:0]);
    whit = regval(awa_q);
  end
  assign iack = ar_fire && araddr[7:0] == `OFF_ACK && nrif.win_valid;   // [RULE25]
  assign fack = ar_fire && araddr[7:0] == `OFF_FACK && frif.win_valid;  // [RULE27]
  assign ieoi = wr_go && awa_q == `OFF_END && nrif.top_valid;
  assign feoi = wr_go && awa_q == `OFF_FEND && frif.top_valid;
  assign iack_oh = iack ? NI'(1) << nrif.win_idx : '0;
  assign fack_oh = fack ? NF'(1) << frif.win_idx : '0;
  assign ieoi_oh = ieoi ? NI'(1) << nrif.top_idx : '0;           // [RULE23]
  assign feoi_oh = feoi ? NF'(1) << frif.top_idx : '0;

  always_comb
  begin
    m       = merge(whit[31:0], wd_q, ws_q);
    clr     = '0;
    sw_set  = '0;
    lock_d  = lock_q;
    sela_d  = sela_q;
    selb_d  = selb_q;
    gdis_d  = gdis_q;
    mask_d  = mask_q;
    fmask_d = fmask_q;
    trig_d  = trig_q;
    edge_d  = edge_q;
    sw_d    = sw_q;
    prio_d  = prio_q;
    fprio_d = fprio_q;
    aw_d    = aw_q;
    awa_d   = awa_q;
    w_d     = w_q;
    wd_d    = wd_q;
    ws_d    = ws_q;
    bv_d    = bv_q & ~bready;
    br_d    = br_q;
    rv_d    = rv_q & ~rready;
    rd_d    = rd_q;
    rr_d    = rr_q;
    if (awvalid && !aw_q)
    begin
      aw_d  = 1'b1;
      awa_d = awaddr[7:0];
    end
    if (wvalid && !w_q)
    begin
      w_d  = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    if (ar_fire)
    begin
      rv_d = 1'b1;
      rd_d = rhit[31:0];
      rr_d = rhit[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = whit[32] ? RESP_OKAY : RESP_SLVERR;
      if (awa_q == `OFF_LOCK)
        lock_d = {m[7], 3'h0, m[3:0]};
      else if (awa_q == `OFF_SELA)
        sela_d = {m[7], 3'h0, m[3:0]};
      else if (awa_q == `OFF_SELB)
        selb_d = {m[7], 3'h0, m[3:0]};
      else if (awa_q == `OFF_CLR)
        clr = NI'(1) << wd_q[3:0];                               // [RULE19]
      else if (awa_q == `OFF_GLOBAL_IRQ_DISABLE)
        gdis_d = m[0];
      else if (awa_q >= `OFF_FPRIO0 && awa_q <= `OFF_FPRIO7 && awa_q[1:0] == 2'b00)
        fprio_d[3'((awa_q - `OFF_FPRIO0) >> 2)] = m[2:0];
      else if (awa_q == `OFF_FMASK)
        fmask_d = m[7:0];
      else if (awa_q == `OFF_MASK)
        mask_d = m[15:0];
      else if (awa_q == `OFF_TRIG)
        trig_d = m[23:0];
      else if (awa_q == `OFF_EDGE)
        edge_d = m[23:0];
      else if (awa_q == `OFF_SW)
      begin
        sw_d   = m[15:0];
        sw_set = m[15:0];                                        // [RULE20]
      end
      else if (awa_q >= `OFF_PRIO0 && awa_q <= `OFF_PRIO15 && awa_q[1:0] == 2'b00)
        prio_d[4'((awa_q - `OFF_PRIO0) >> 2)] = m[3:0];          // [RULE8]
    end
    // New detections win over any clear in the same cycle
    ireq_d = (ireq_q & ~clr & ~iack_oh) | det[NI-1:0] | sw_set;  // [RULE16] [RULE21]
    freq_d = (freq_q & ~fack_oh) | det[NT-1:NI];                 // [RULE18]
    isr_d  = (isr_q & ~ieoi_oh) | iack_oh;                       // [RULE21] [RULE23]
    fisr_d = (fisr_q & ~feoi_oh) | fack_oh;                      // [RULE27]
    // Output follows the resolver one cycle late, so a lock race lasts at most two
    irq_d  = nrif.win_valid & ~iack;                             // [RULE13] [RULE22]
    fiq_d  = frif.win_valid & ~fack;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ireq_q  <= '0;
      freq_q  <= '0;
      isr_q   <= '0;
      fisr_q  <= '0;
      mask_q  <= `MASK_RST;                                      // [RULE17]
      fmask_q <= `FMASK_RST;                                     // [RULE18]
      gdis_q  <= `GLOBAL_IRQ_DISABLE_RST;
      lock_q  <= '0;                                             // [RULE12]
      sela_q  <= '0;                                             // [RULE4]
      selb_q  <= '0;
      trig_q  <= '0;                                             // [RULE14]
      edge_q  <= '0;
      sw_q    <= '0;
      prio_q  <= '{default: `PRIO_RST};                          // [RULE9]
      fprio_q <= '{default: `FPRIO_RST};
      irq_q   <= 1'b0;
      fiq_q   <= 1'b0;
      aw_q    <= 1'b0;
      awa_q   <= '0;
      w_q     <= 1'b0;
      wd_q    <= '0;
      ws_q    <= '0;
      bv_q    <= 1'b0;
      br_q    <= RESP_OKAY;
      rv_q    <= 1'b0;
      rd_q    <= '0;
      rr_q    <= RESP_OKAY;
    end
    else
    begin
      ireq_q  <= ireq_d;
      freq_q  <= freq_d;
      isr_q   <= isr_d;
      fisr_q  <= fisr_d;
      mask_q  <= mask_d;
      fmask_q <= fmask_d;
      gdis_q  <= gdis_d;
      lock_q  <= lock_d;
      sela_q  <= sela_d;
      selb_q  <= selb_d;
      trig_q  <= trig_d;
      edge_q  <= edge_d;
      sw_q    <= sw_d;
      prio_q  <= prio_d;
      fprio_q <= fprio_d;
      irq_q   <= irq_d;
      fiq_q   <= fiq_d;
      aw_q    <= aw_d;
      awa_q   <= awa_d;
      w_q     <= w_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  vec_default_a: assert property (ar_fire && araddr[7:0] == `OFF_VEC       // [RULE26]
      && !nrif.win_valid |=> rdata == `VEC_DEFAULT) else $error("default vector wrong");
  ack_service_a: assert property (iack |=> isr_q[$past(nrif.win_idx)]      // [RULE21]
      && !irq_out) else $error("acknowledge did not enter service");
  peek_quiet_a: assert property (ar_fire && araddr[7:0] == `OFF_VEC        // [RULE25]
      |=> isr_q == $past(isr_q) || $past(ieoi)) else $error("peek read changed service");
  mask_latch_a: assert property ((det[NI-1:0] & mask_q) != '0              // [RULE16]
      |=> (ireq_q & $past(det[NI-1:0] & mask_q)) == $past(det[NI-1:0] & mask_q))
      else $error("masked request not latched");
  lock_block_a: assert property (nrif.lock_en && nrif.win_valid            // [RULE11]
      |-> nrif.win_prio < nrif.lock_prio) else $error("locked priority passed");
  nest_block_a: assert property (nrif.win_valid && nrif.top_valid          // [RULE22]
      |-> nrif.win_prio < nrif.top_prio) else $error("lower priority passed service");
  eoi_clear_a: assert property (ieoi && !iack                              // [RULE23]
      |=> !isr_q[$past(nrif.top_idx)]) else $error("end did not clear service");
  reset_prio_a: assert property ($past(!aresetn) |-> nrif.prio == {NI{`PRIO_RST}}  // [RULE9]
      && frif.prio == {NF{`FPRIO_RST}}) else $error("priority reset wrong");
  sw_entry_a: assert property (sw_set != '0                                // [RULE20]
      |=> (ireq_q & $past(sw_set)) == $past(sw_set)) else $error("soft request lost");
  lock_race_a: assert property (irq_out && !nrif.win_valid                 // [RULE13]
      |=> !irq_out) else $error("output held past blocking");
  reroute_off_a: assert property (!sela_q[`EN_BIT]                         // [RULE4]
      |-> fast_in[`LANE_A] == f_q[NI + `LANE_A]) else $error("reroute while disabled");

  nested_c: cover property (iack && isr_q != '0);
  fast_ack_c: cover property (fack && sela_q[`EN_BIT]);
  lock_hit_c: cover property (nrif.lock_en && nrif.pend != '0 && !nrif.win_valid);
  eoi_c: cover property (feoi);
endmodule

// *** verification/cpu_model.sv ***
// Processor side model: AXI4-Lite master for vector reads and end commands
`timescale 1ns/1ps
module cpu_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int hangs = 0;
  initial
  begin
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
  end
  // Response code 3 is never sent, so it marks a write that never finished
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64 && r === 2'h3; n++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        r = bresp;
    end
    bready <= 1'b0;
    if (r === 2'h3)
      hangs++;
  endtask
  // A read at the second vector address, 8'h14, counts as the acknowledge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64 && r === 2'h3; n++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
    if (r === 2'h3)
      hangs++;
  endtask
  // Any written value serves as the end command
  task automatic end_of_interrupt_cmd(input logic fast);
    logic [1:0] r;
    wr(fast ? 8'h28 : 8'h24, 32'h5a, 4'hf, r);
  endtask
endmodule

// *** verification/nested_vectored_interrupt_unit_tb_top.sv ***
// Self-checking bench for the nested vectored interrupt unit
`timescale 1ns/1ps
module nested_vectored_interrupt_unit_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] irq_src = 16'h0;
  logic [7:0]  fast_src = 8'h0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq_out, fast_out;
  int          fail_count = 0;
  int          checked = 0;
  nested_vectored_interrupt_unit uut (.aclk(aclk), .aresetn(aresetn), .irq_src(irq_src),
    .fast_src(fast_src), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq_out(irq_out), .fast_out(fast_out));
  cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    cpu.rd(a, v, r);
    chk(v, e);
    chk({30'h0, r}, 32'h0);
  endtask
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    cpu.wr(a, d, 4'hf, r);
    chk({30'h0, r}, 32'h0);
  endtask
  // Two-cycle pulse covers the synchroniser at this clock
  task automatic pulse(input logic [15:0] m, input logic [7:0] f);
    @(posedge aclk);
    irq_src <= m;
    fast_src <= f;
    repeat (2) @(posedge aclk);
    irq_src <= 16'h0;
    fast_src <= 8'h0;
  endtask
  // Expected {irq_out, fast_out}; a low expectation waits the full settle time
  task automatic sett(input logic [1:0] e);
    int n;
    for (n = 0; n < 12; n++)
    begin
      @(posedge aclk);
      if (e != 2'b00 && {irq_out, fast_out} === e)
        break;
    end
    chk({30'h0, irq_out, fast_out}, {30'h0, e});
  endtask
  task automatic t_reset;
    rdc(8'h00, 32'hffff_ffff);
    rdc(8'h14, 32'hffff_ffff);
    rdc(8'h70, 32'h0000_000f);
    rdc(8'hac, 32'h0000_000f);
    rdc(8'h48, 32'h0000_0007);
    rdc(8'h5c, 32'h0000_ffff);
    rdc(8'h20, 32'h0000_0001);
    rdc(8'h54, 32'h0000_00ff);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    // Byte zero left out of the strobe, so the priority keeps its reset value
    cpu.wr(8'h70, 32'h3, 4'he, r);
    rdc(8'h70, 32'h0000_000f);
    cpu.rd(8'hb0, v, r);
    chk({30'h0, r}, 32'h2);
    cpu.wr(8'hb4, 32'h1, 4'hf, r);
    chk({30'h0, r}, 32'h2);
  endtask
  task automatic t_mask;
    pulse(16'h0008, 8'h0);
    sett(2'b00);
    rdc(8'h58, 32'h8);
    wrr(8'h1c, 32'h3);
    rdc(8'h58, 32'h0);
    wrr(8'h5c, 32'h0);
    pulse(16'h0008, 8'h0);
    sett(2'b00);
    wrr(8'h20, 32'h0);
    sett(2'b10);
    rdc(8'h14, 32'h3);
    sett(2'b00);
    cpu.end_of_interrupt_cmd(1'b0);
    rdc(8'h60, 32'h0);
  endtask
  // Priorities change only while nothing is in service
  task automatic t_nest;
    wrr(8'h78, 32'h5);
    wrr(8'h84, 32'h1);
    wrr(8'h6c, 32'h0204);
    sett(2'b10);
    rdc(8'h00, 32'h2);
    rdc(8'h14, 32'h2);
    sett(2'b00);
    rdc(8'h58, 32'h0200);
    wrr(8'h6c, 32'h0020);
    sett(2'b10);
    rdc(8'h14, 32'h5);
    rdc(8'h60, 32'h0024);
    cpu.end_of_interrupt_cmd(1'b0);
    rdc(8'h60, 32'h0004);
    sett(2'b00);
    cpu.end_of_interrupt_cmd(1'b0);
    sett(2'b10);
    rdc(8'h14, 32'h9);
    cpu.end_of_interrupt_cmd(1'b0);
  endtask
  task automatic t_lock;
    wrr(8'h08, 32'h85);
    wrr(8'h6c, 32'h0004);
    sett(2'b00);
    wrr(8'h6c, 32'h0020);
    sett(2'b10);
    rdc(8'h14, 32'h5);
    cpu.end_of_interrupt_cmd(1'b0);
    wrr(8'h08, 32'h05);
    sett(2'b10);
    wrr(8'h08, 32'h85);
    sett(2'b00);
    rdc(8'h14, 32'hffff_ffff);
    wrr(8'h08, 32'h05);
    sett(2'b10);
    rdc(8'h14, 32'h2);
    cpu.end_of_interrupt_cmd(1'b0);
  endtask
  task automatic t_trig;
    wrr(8'h80, 32'h3);
    wrr(8'h64, 32'h0100);
    wrr(8'h68, 32'h0010);
    irq_src <= 16'h0110;
    sett(2'b10);
    rdc(8'h14, 32'h8);
    irq_src <= 16'h0;
    sett(2'b10);
    rdc(8'h14, 32'h4);
    wrr(8'h1c, 32'h8);
    cpu.end_of_interrupt_cmd(1'b0);
    cpu.end_of_interrupt_cmd(1'b0);
    rdc(8'h60, 32'h0);
  endtask
  task automatic t_fast;
    wrr(8'h54, 32'h0);
    wrr(8'h30, 32'h2);
    wrr(8'h34, 32'h1);
    pulse(16'h0, 8'h02);
    sett(2'b01);
    rdc(8'h18, 32'h1);
    pulse(16'h0, 8'h04);
    sett(2'b01);
    rdc(8'h18, 32'h2);
    cpu.end_of_interrupt_cmd(1'b1);
    rdc(8'h4c, 32'h2);
    cpu.end_of_interrupt_cmd(1'b1);
    wrr(8'h10, 32'h0c);
    wrr(8'h0c, 32'h8b);
    wrr(8'h5c, 32'h1800);
    pulse(16'h1800, 8'h0);
    sett(2'b01);
    rdc(8'h50, 32'h40);
    rdc(8'h18, 32'h6);
    cpu.end_of_interrupt_cmd(1'b1);
  endtask
  task automatic give_verdict;
    fail_count += cpu.hangs;
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // A bus wait that ran out ends the run at once
  always @(posedge aclk)
    if (cpu.hangs != 0)
      give_verdict();
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_nest();
    t_lock();
    t_trig();
    t_fast();
    give_verdict();
  end
endmodule
